// ---- logic/dsp_ds_transceiver.sv ----
/*
  Two-port cable datapath: link capture, serializer with data-strobe
  encoding, receive decode and nibble repeat, line-state and speed
  latching, and connect debounce with bus reset.
  Assumes all pin-group inputs are asynchronous to mclk; arb_phase
  comes from the arbiter on mclk. The link system clock is a pin that
  mclk samples.
*/
// Notes on behaviour
// RL1: link data lines are captured on rising edges of the system clock.
// RL2: captured bits are serialized, data-strobe encoded, sent at the latched speed's rate; S400 goes out at one bit per mclk cycle instead.
// RL3: transmit puts data on the second pair, strobe on the first.
// RL4: a receiving port has both transmitters off and its receivers on.
// RL5: receive takes data from the first pair, strobe from the second.
// RL6: data xor strobe recovers the bit clock and the serial bits.
// RL7: received bits form nibbles, repeated out of other connected ports.
// RL8: received lines are resynchronized into the mclk domain.
// RL9: arbitration status comes from both pairs' comparators.
// RL10: first-pair common-mode speed sets the next transmission speed.
// RL11: bias seen on the second pair means connected, else disconnected.
// RL12: connect is debounced; the debounced connect starts a bus reset.
// RL13: disconnect is reflected at once without any debounce.
// RL14: connect debounce length is a parameter in mclk cycles.
`timescale 1ns/1ps

module dsp_ds_transceiver
  import dsp_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = `DSP_DEBOUNCE_CYC
)
(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     sysclk_pin,
  input  wire logic                     link_tx_req,
  input  wire logic [7:0]               link_data_lines,
  input  wire logic                     arb_phase,
  input  wire dsp_ports_in_t            port_in,
  output dsp_port_out_s [`DSP_NPORT-1:0] port_out,
  output logic [`DSP_NPORT-1:0]         port_bias_output,
  output logic [`DSP_NPORT-1:0]         connected,
  output logic                          bus_reset,
  output dsp_arb_s [`DSP_NPORT-1:0]     arb_status,
  output dsp_speed_e                    tx_speed,
  output logic                          tx_busy,
  output dsp_nib_s                      rx_nib
);

  localparam logic [19:0] MCLK_KHZ = 20'(`DSP_MCLK_KHZ);

  logic [`DSP_SYNC_W-1:0] sync1_q;
  logic [`DSP_SYNC_W-1:0] sync2_q;
  logic                   sysclk_s;
  logic                   req_s;
  logic [7:0]             data_s;
  dsp_ports_in_t          pin_s;
  logic                   sysclk_d_q;
  logic                   cap_edge;

  logic [19:0]            acc_q;
  logic [19:0]            rate;
  logic [20:0]            acc_sum;
  logic                   bit_en;
  logic [3:0]             nbits;

  logic [7:0]             tx_sh_q;
  logic [3:0]             tx_cnt_q;
  logic                   ds_data_q;
  logic                   ds_strobe_q;
  logic                   tx_tail_q;
  dsp_speed_e             speed_q;

  logic [`DSP_NPORT-1:0]  rx_evt;
  logic [`DSP_NPORT-1:0]  rx_bit;
  logic                   rx_act_q;
  logic                   rx_sel_q;
  logic [7:0]             idle_q;
  logic [3:0]             nib_sh_q;
  logic [1:0]             nib_cnt_q;
  logic                   sel_evt;
  logic                   nib_done;
  logic [3:0]             nib_next;
  logic                   rx_start;
  logic                   cur_sel;

  logic [`DSP_NPORT-1:0]  conn_q;
  logic [`DSP_NPORT-1:0]  conn_prev_q;

  // pins cross into mclk through two flops; only sync2 is read
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {sysclk_pin, link_tx_req, link_data_lines, port_in};
      sync2_q <= sync1_q; // RL8
    end
  end

  assign sysclk_s = sync2_q[23];
  assign req_s    = sync2_q[22];
  assign data_s   = sync2_q[21:14];
  assign pin_s    = dsp_ports_in_t'(sync2_q[13:0]);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      sysclk_d_q <= 1'b0;
    else
      sysclk_d_q <= sysclk_s;
  end

  assign cap_edge = sysclk_s & ~sysclk_d_q; // RL1

  // bit enable from a rate accumulator; 400 rate saturates at one per cycle
  always_comb
  begin
    case (speed_q)
      SPD_S200:
      begin
        rate  = 20'(`DSP_RATE_S200_KBPS);
        nbits = `DSP_BITS_S200;
      end
      SPD_S400:
      begin
        rate  = 20'(`DSP_RATE_S400_KBPS);
        nbits = `DSP_BITS_S400;
      end
      default:
      begin
        rate  = 20'(`DSP_RATE_S100_KBPS);
        nbits = `DSP_BITS_S100;
      end
    endcase
    acc_sum = {1'b0, acc_q} + {1'b0, rate};
    bit_en  = (acc_sum >= {1'b0, MCLK_KHZ});
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      acc_q <= '0;
    else if (rate >= MCLK_KHZ)
      acc_q <= '0;
    else if (bit_en)
      acc_q <= 20'(acc_sum - {1'b0, MCLK_KHZ}); // RL2
    else
      acc_q <= acc_sum[19:0];
  end

  // receive decode per port
  generate
    for (genvar p = 0; p < `DSP_NPORT; p++)
    begin : g_rx
      logic data_prev_q;
      logic strb_prev_q;

      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          data_prev_q <= 1'b0;
          strb_prev_q <= 1'b0;
        end
        else
        begin
          data_prev_q <= pin_s[p].first_i; // RL5
          strb_prev_q <= pin_s[p].second_i; // RL5
        end
      end

      // a change of data^strobe is one recovered bit clock edge
      assign rx_evt[p] = (pin_s[p].first_i ^ pin_s[p].second_i)
                         != (data_prev_q ^ strb_prev_q); // RL6
      assign rx_bit[p] = pin_s[p].first_i; // RL6
    end
  endgenerate

  // the change that opens a reception is already bit 0
  assign rx_start = !rx_act_q & (tx_cnt_q == '0) & |(rx_evt & conn_q);
  assign cur_sel  = rx_act_q ? rx_sel_q : !(rx_evt[0] & conn_q[0]);
  assign sel_evt  = rx_act_q ? rx_evt[rx_sel_q] : rx_start; // RL6
  assign nib_next = {rx_bit[cur_sel], nib_sh_q[3:1]};
  assign nib_done = sel_evt & rx_act_q & (nib_cnt_q == `DSP_NIB_LAST);

  // first active connected port wins reception while idle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rx_act_q <= 1'b0;
      rx_sel_q <= 1'b0;
      idle_q   <= '0;
    end
    else if (!rx_act_q)
    begin
      idle_q   <= '0;
      rx_act_q <= rx_start;
      rx_sel_q <= cur_sel;
    end
    else if (sel_evt)
      idle_q <= '0;
    else if (idle_q == `DSP_RX_IDLE_CYC - 8'h1 || !conn_q[rx_sel_q])
      rx_act_q <= 1'b0;
    else
      idle_q <= idle_q + 8'h1;
  end

  // serial bits into nibbles, lsb first
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      nib_sh_q  <= '0;
      nib_cnt_q <= '0;
      rx_nib    <= '0;
    end
    else
    begin
      rx_nib.valid <= 1'b0;
      if (sel_evt)
      begin
        nib_sh_q  <= nib_next;
        nib_cnt_q <= rx_act_q ? nib_cnt_q + 2'h1 : 2'h1; // RL7
      end
      else if (!rx_act_q)
        nib_cnt_q <= '0;
      if (nib_done)
      begin
        rx_nib.valid <= 1'b1;
        rx_nib.port  <= rx_sel_q;
        rx_nib.data  <= nib_next; // RL7
      end
    end
  end

  // one serializer: link data when idle, repeat nibbles while receiving
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      tx_sh_q     <= '0;
      tx_cnt_q    <= '0;
      ds_data_q   <= 1'b0;
      ds_strobe_q <= 1'b0;
    end
    else if (nib_done)
    begin
      tx_sh_q  <= {4'h0, nib_next}; // RL7
      tx_cnt_q <= 4'h4;
    end
    else if (cap_edge & req_s & !rx_act_q)
    begin
      tx_sh_q  <= data_s; // RL1
      tx_cnt_q <= nbits;
    end
    else if (bit_en && tx_cnt_q != '0)
    begin
      ds_data_q <= tx_sh_q[0];
      // strobe toggles only when data repeats
      if (tx_sh_q[0] == ds_data_q)
        ds_strobe_q <= ~ds_strobe_q; // RL2
      tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
      tx_cnt_q <= tx_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      tx_busy   <= 1'b0;
      tx_tail_q <= 1'b0;
    end
    else
    begin
      tx_busy   <= (tx_cnt_q != '0) | (req_s & !rx_act_q);
      tx_tail_q <= (tx_cnt_q != '0) | (tx_tail_q & !bit_en);
    end
  end

  // line states and speed are only meaningful during arbitration
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      arb_status <= '0;
      speed_q    <= SPD_S100;
    end
    else if (arb_phase)
    begin
      for (int i = 0; i < `DSP_NPORT; i++)
      begin
        arb_status[i].cmp_first  <= pin_s[i].cmp_first; // RL9
        arb_status[i].cmp_second <= pin_s[i].cmp_second; // RL9
      end
      for (int i = `DSP_NPORT - 1; i >= 0; i--)
      begin
        if (conn_q[i])
        begin
          case (pin_s[i].spd_det)
            `DSP_SPD_CODE_S200: speed_q <= SPD_S200; // RL10
            `DSP_SPD_CODE_S400: speed_q <= SPD_S400; // RL10
            default:            speed_q <= SPD_S100; // RL10
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      tx_speed <= SPD_S100;
    else
      tx_speed <= speed_q;
  end

  // per-port connection and line drivers
  generate
    for (genvar p = 0; p < `DSP_NPORT; p++)
    begin : g_port
      logic [19:0] deb_q;
      logic        rx_here;
      logic        send;

      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          deb_q     <= '0;
          conn_q[p] <= 1'b0;
        end
        else if (!pin_s[p].bias_det)
        begin
          deb_q     <= '0;
          conn_q[p] <= 1'b0; // RL13
        end
        else if (!conn_q[p])
        begin
          // bias must hold unbroken for the whole interval
          if (deb_q >= 20'(DEBOUNCE_CYC - 1))
            conn_q[p] <= 1'b1; // RL11 RL14
          else
            deb_q <= deb_q + 20'h1; // RL12
        end
      end

      assign rx_here = rx_act_q & (rx_sel_q == 1'(p));
      // pins lag the shifter a cycle; oe holds through the last bit
      assign send    = conn_q[p] & !rx_here
                       & (rx_act_q | (tx_cnt_q != '0) | tx_tail_q);

      always_ff @(posedge mclk)
      begin
        if (!resetn)
          port_out[p] <= '0;
        else
        begin
          port_out[p].first_o   <= ds_strobe_q; // RL3
          port_out[p].second_o  <= ds_data_q; // RL3
          port_out[p].first_oe  <= send; // RL4
          port_out[p].second_oe <= send; // RL4
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      conn_prev_q      <= '0;
      connected        <= '0;
      bus_reset        <= 1'b0;
      port_bias_output <= '0;
    end
    else
    begin
      conn_prev_q      <= conn_q;
      connected        <= conn_q; // RL13
      bus_reset        <= |(conn_q & ~conn_prev_q); // RL12
      port_bias_output <= '1;
    end
  end

endmodule : dsp_ds_transceiver

// ---- include/dsp_map.svh ----
/*
  Offsets-free constant map for the cable-port data-strobe transceiver:
  rates, clock figures, speed codes, widths and timing counts.
  Assumes it is included by bare name before the package and the logic.
*/
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

`define DSP_NPORT          2
`define DSP_MCLK_KHZ       200000
`define DSP_SYSCLK_KHZ     49152
`define DSP_RATE_S100_KBPS 98304
`define DSP_RATE_S200_KBPS 196608
`define DSP_RATE_S400_KBPS 393216
`define DSP_BITS_S100      4'h2
`define DSP_BITS_S200      4'h4
`define DSP_BITS_S400      4'h8
`define DSP_DEBOUNCE_CYC   1000
`define DSP_RX_IDLE_CYC    8'h10
`define DSP_SPD_CODE_S200  2'h1
`define DSP_SPD_CODE_S400  2'h2
`define DSP_NIB_LAST       2'h3
`define DSP_SYNC_W         24

`endif

// ---- include/dsp_pkg.sv ----
/*
  Types for the cable-port data-strobe transceiver: speed enum and the
  packed structs that carry per-port pin groups and the repeat nibble.
  Assumes dsp_map.svh is visible for the port count.
*/
`include "dsp_map.svh"

package dsp_pkg;

  typedef enum logic [1:0] {SPD_S100, SPD_S200, SPD_S400} dsp_speed_e;

  typedef struct packed {
    logic       first_i;
    logic       second_i;
    logic       cmp_first;
    logic       cmp_second;
    logic       bias_det;
    logic [1:0] spd_det;
  } dsp_port_in_s;

  typedef struct packed {
    logic first_o;
    logic first_oe;
    logic second_o;
    logic second_oe;
  } dsp_port_out_s;

  typedef struct packed {
    logic cmp_first;
    logic cmp_second;
  } dsp_arb_s;

  typedef struct packed {
    logic       valid;
    logic       port;
    logic [3:0] data;
  } dsp_nib_s;

  typedef dsp_port_in_s [`DSP_NPORT-1:0] dsp_ports_in_t;

endpackage : dsp_pkg

// ---- sim/dsp_ds_transceiver_sva.sv ----
/*
  Port checker for the cable-port transceiver.
  Assumes a bind onto dsp_ds_transceiver, one mclk domain.
*/
`timescale 1ns/1ps
`include "dsp_map.svh"
module dsp_chk_sva
  import dsp_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = 4
)
(
  input wire logic                          mclk,
  input wire logic                          resetn,
  input wire logic                          arb_phase,
  input wire dsp_ports_in_t                 port_in,
  input wire dsp_port_out_s [`DSP_NPORT-1:0] port_out,
  input wire logic [`DSP_NPORT-1:0]         connected,
  input wire logic                          bus_reset,
  input wire dsp_arb_s [`DSP_NPORT-1:0]     arb_status,
  input wire dsp_speed_e                    tx_speed,
  input wire logic                          tx_busy,
  input wire dsp_nib_s                      rx_nib
);
  int unsigned hi_q;
  // counts raw bias cycles, so sync delay only adds slack
  always_ff @(posedge mclk)
  begin
    if (!resetn || !port_in[0].bias_det)
      hi_q <= 0;
    else
      hi_q <= hi_q + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_oe_paired: assert property (port_out[0].first_oe == port_out[0].second_oe
    && port_out[1].first_oe == port_out[1].second_oe)
    else $error("pair enables differ");
  a_rx_tx_off: assert property (rx_nib.valid && !rx_nib.port |->
    !port_out[0].first_oe && !port_out[0].second_oe)
    else $error("receiving port drives");
  a_rx_nib_pulse: assert property (rx_nib.valid |=> !rx_nib.valid)
    else $error("nibble valid too long");
  a_rx_repeat_on: assert property (rx_nib.valid && !rx_nib.port &&
    connected[1] |-> port_out[1].second_oe)
    else $error("no repeat enable");
  a_arb_hold: assert property (!arb_phase |=> $stable(arb_status))
    else $error("arb status moved");
  a_arb_follow: assert property ((arb_phase &&
    $stable(port_in[0].cmp_first))[*4] |->
    arb_status[0].cmp_first == port_in[0].cmp_first)
    else $error("arb status stale");
  a_speed_hold: assert property (!arb_phase |=> $stable(tx_speed))
    else $error("speed moved");
  a_conn_wait: assert property ($rose(connected[0]) |->
    hi_q >= DEBOUNCE_CYC)
    else $error("connect too early");
  a_busrst_cause: assert property (bus_reset |->
    |(connected & ~$past(connected)))
    else $error("bus reset without connect");
  a_disc_fast: assert property ($fell(port_in[1].bias_det) |->
    ##[1:4] !connected[1])
    else $error("disconnect slow");
  c_busrst: cover property (bus_reset);
  c_rx: cover property (rx_nib.valid);
  c_tx: cover property (tx_busy && port_out[1].second_oe);
endmodule : dsp_chk_sva

bind dsp_ds_transceiver dsp_chk_sva #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) chk_i (
  .mclk(mclk), .resetn(resetn), .arb_phase(arb_phase), .port_in(port_in),
  .port_out(port_out), .connected(connected), .bus_reset(bus_reset),
  .arb_status(arb_status), .tx_speed(tx_speed), .tx_busy(tx_busy),
  .rx_nib(rx_nib));

// ---- sim/dsp_far_model.sv ----
/*
  Far side: free link clock pin and the remote cable nodes.
  Assumes the bench calls its tasks just after mclk edges.
*/
`timescale 1ns/1ps
module dsp_far_model
  import dsp_pkg::*;
(
  input  wire logic     mclk,
  output logic          sysclk_pin,
  output dsp_ports_in_t port_in
);
  dsp_ports_in_t pin_q;
  assign port_in = pin_q;
  initial
  begin
    pin_q = '0;
    sysclk_pin = 1'b0;
    #1.7;
    forever #32 sysclk_pin = ~sysclk_pin;
  end
  task automatic set_bias(input int p, input logic v);
    pin_q[p].bias_det <= v;
  endtask : set_bias
  // one line flips per bit: strobe only when the bit repeats
  task automatic send_nib(input int p, input logic [3:0] nib, input int gap);
    for (int b = 0; b < 4; b++)
    begin
      repeat (gap) @(posedge mclk);
      if (pin_q[p].first_i == nib[b])
        pin_q[p].second_i <= ~pin_q[p].second_i;
      else
        pin_q[p].first_i <= nib[b];
    end
  endtask : send_nib
endmodule : dsp_far_model

// ---- sim/dsp_ds_transceiver_tb.sv ----
/*
  Self-checking bench for the cable-port transceiver.
  Assumes dsp_far_model on the far side; port 1 decoded as seen.
*/
`timescale 1ns/1ps
`include "dsp_map.svh"
module dsp_ds_transceiver_tb
  import dsp_pkg::*;
;
  localparam int DEB = 4;
  logic mclk, resetn, link_tx_req, arb_phase, sysclk_pin, bus_reset, tx_busy;
  logic [7:0]                      link_data_lines;
  logic [1:0]                      port_bias_output, connected;
  dsp_ports_in_t                   port_in;
  dsp_port_out_s [`DSP_NPORT-1:0]  port_out;
  dsp_arb_s [`DSP_NPORT-1:0]       arb_status;
  dsp_speed_e                      tx_speed;
  dsp_nib_s                        rx_nib;
  int err_total, tests_run;
  logic par_q;
  logic obs[$];
  logic [3:0] exp_nib[$];
  dsp_ds_transceiver #(.DEBOUNCE_CYC(DEB)) dsp_ds_transceiver_i (
    .mclk(mclk), .resetn(resetn), .sysclk_pin(sysclk_pin),
    .link_tx_req(link_tx_req), .link_data_lines(link_data_lines),
    .arb_phase(arb_phase), .port_in(port_in), .port_out(port_out),
    .port_bias_output(port_bias_output), .connected(connected),
    .bus_reset(bus_reset), .arb_status(arb_status), .tx_speed(tx_speed),
    .tx_busy(tx_busy), .rx_nib(rx_nib));
  dsp_far_model dsp_far_model_i (.mclk(mclk), .sysclk_pin(sysclk_pin),
    .port_in(port_in));
  task final_report;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask : chk
  task lim(input int i, input int m);
    if (i >= m)
    begin
      err_total++;
      final_report();
    end
  endtask : lim
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // port 1 decoded from the wire: each d^s change is one bit
  always @(posedge mclk)
  begin
    if (port_out[1].second_oe === 1'b1 &&
        (port_out[1].second_o ^ port_out[1].first_o) !== par_q)
      obs.push_back(port_out[1].second_o);
    par_q <= port_out[1].second_o ^ port_out[1].first_o;
  end
  always @(posedge mclk)
    if (rx_nib.valid === 1'b1)
      chk("rx_nib", {1'b0, exp_nib.pop_front()},
          {rx_nib.port, rx_nib.data});
  initial
  begin
    int i;
    logic [7:0] d;
    logic [7:0] rep;
    resetn = 1'b0;
    link_tx_req = 1'b0;
    link_data_lines = 8'h00;
    arb_phase = 1'b0;
    par_q = 1'b0;
    err_total = 0;
    tests_run = 0;
    i = $urandom(5);
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("bias_out", 2'h3, port_bias_output);
    chk("connected", 2'h0, connected);
    for (int p = 0; p < 2; p++)
    begin
      dsp_far_model_i.set_bias(p, 1'b1);
      for (i = 0; i < 40 && connected[p] !== 1'b1; i++)
        @(posedge mclk);
      lim(i, 40);
      chk("conn_early", 1, i >= DEB);
      chk("bus_reset", 1, bus_reset);
      @(posedge mclk);
    end
    arb_phase <= 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      d = $urandom;
      dsp_far_model_i.pin_q[0].spd_det <= s[1:0];
      dsp_far_model_i.pin_q[1].spd_det <= 2'h2 - s[1:0];
      for (int p = 0; p < 2; p++)
      begin
        dsp_far_model_i.pin_q[p].cmp_first <= d[2*p+1];
        dsp_far_model_i.pin_q[p].cmp_second <= d[2*p];
      end
      repeat (6) @(posedge mclk);
      chk("speed", s, tx_speed);
      chk("arb", d[3:0], arb_status);
    end
    arb_phase <= 1'b0;
    obs.delete();
    d = $urandom;
    link_data_lines <= d;
    link_tx_req <= 1'b1;
    repeat (26) @(posedge mclk);
    chk("tx_busy", 1, tx_busy);
    link_tx_req <= 1'b0;
    for (i = 0; i < 100 && tx_busy !== 1'b0; i++)
      @(posedge mclk);
    lim(i, 100);
    // last bit reaches the decoder one edge after busy drops
    repeat (2) @(posedge mclk);
    for (int b = 0; b < 8; b++)
      chk("tx_bit", d[b], obs[b]);
    obs.delete();
    for (int n = 0; n < 2; n++)
    begin
      d = $urandom;
      exp_nib.push_back(d[3:0]);
      rep[4*n +: 4] = d[3:0];
      dsp_far_model_i.send_nib(0, d[3:0], 3);
    end
    repeat (30) @(posedge mclk);
    chk("rx_count", 0, exp_nib.size());
    for (int b = 0; b < 8; b++)
      chk("rep_bit", rep[b], obs[b]);
    dsp_far_model_i.set_bias(1, 1'b0);
    repeat (5) @(posedge mclk);
    chk("disc", 2'h1, connected);
    final_report();
  end
endmodule : dsp_ds_transceiver_tb
